/* File: design/uie_top.sv */
// USB general interrupt enable register with status and Wishbone slave
//
// Added by the designer: the Wishbone interface to the registers.
`include "uie_params.svh"
module uie_top (
  input  wire logic       clk_i,       // System clock, 10 MHz
  input  wire logic       rst_i,       // Synchronous reset, active high
  input  wire logic       host_mode_i, // 1 host role, 0 device role
  input  wire logic       suspended_i, // Controller in suspended state
  input  wire logic       sof_sent_i,  // Pulse: SOF transmitted (host)
  input  wire logic [7:0] event_i,     // Raw source pulses, bit layout
  input  wire logic       wb_cyc_i,    // Wishbone cycle
  input  wire logic       wb_stb_i,    // Wishbone strobe
  input  wire logic       wb_we_i,     // Wishbone write enable
  input  wire logic [7:0] wb_adr_i,    // Wishbone byte address
  input  wire logic [3:0] wb_sel_i,    // Wishbone byte selects
  input  wire logic [31:0] wb_dat_i,   // Wishbone write data
  output logic [31:0]     wb_dat_o,    // Wishbone read data
  output logic            wb_ack_o,    // Wishbone acknowledge
  output logic            usb_irq_o,   // Gated request to controller
  output logic            irq_o        // Masked sticky status level
);
  uie_pkg::uie_state_s st_r;
  uie_pkg::uie_state_s st_nxt;
  logic [7:0] wmask;
  logic [7:0] qual;
  logic       req;
  logic       wr_lane0;

  // Sources that the active role does not define never set status and read back as zero from the enable register
  function automatic logic [7:0] role_mask(input logic host);
    role_mask = host ? `UIE_HOST_WMASK : `UIE_DEV_WMASK;
  endfunction : role_mask

  always_comb begin
    wmask = role_mask(host_mode_i);
    qual  = event_i & wmask;
    // In host role, babble only counts once the first frame went out
    if (host_mode_i && !st_r.sof_seen) begin
      qual[`UIE_BIT_BABBLE] = 1'b0;
    end
    if (!suspended_i) begin
      qual[`UIE_BIT_RESUME] = 1'b0;
    end
    req      = wb_cyc_i && wb_stb_i && (st_r.bus == uie_pkg::UIE_IDLE);
    // Writes land on the edge at which the master samples ack, so an
    // aborted cycle leaves the registers untouched
    wr_lane0 = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] &&
               (st_r.bus == uie_pkg::UIE_ACK);
    st_nxt   = st_r;
    st_nxt.bus = uie_pkg::UIE_IDLE;
    if (host_mode_i && sof_sent_i) begin
      st_nxt.sof_seen = 1'b1;
    end
    if (wr_lane0 && wb_adr_i == `UIE_ADDR_ENABLE) begin
      st_nxt.enable = wb_dat_i[7:0] & 8'h3f;
    end
    if (wr_lane0 && wb_adr_i == `UIE_ADDR_MASK) begin
      st_nxt.mask = wb_dat_i[7:0] & 8'h3f;
    end
    // Write one clears; a new event in the same cycle wins
    if (wr_lane0 && wb_adr_i == `UIE_ADDR_STATUS) begin
      st_nxt.status = st_r.status & ~wb_dat_i[7:0];
    end
    st_nxt.status = st_nxt.status | qual;
    if (req) begin
      st_nxt.bus = uie_pkg::UIE_ACK;
      case (wb_adr_i)
        `UIE_ADDR_ENABLE: st_nxt.dat = st_r.enable & wmask;
        `UIE_ADDR_STATUS: st_nxt.dat = st_r.status;
        `UIE_ADDR_MASK:   st_nxt.dat = st_r.mask;
        default:          st_nxt.dat = 8'h00;
      endcase
    end
    if (rst_i) begin
      st_nxt.enable   = `UIE_ENABLE_RESET;
      st_nxt.status   = 8'h00;
      st_nxt.mask     = 8'h00;
      st_nxt.sof_seen = 1'b0;
      st_nxt.dat      = 8'h00;
      st_nxt.bus      = uie_pkg::UIE_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    st_r <= st_nxt;
  end

  assign wb_dat_o  = {24'h000000, st_r.dat};
  assign wb_ack_o  = (st_r.bus == uie_pkg::UIE_ACK);
  // Stored bits only drive usb_irq_o for sources the active role defines; irq_o uses status and mask alone
  assign usb_irq_o = |(st_r.status & st_r.enable & wmask);
  assign irq_o     = |(st_r.status & st_r.mask);

  property p_reset_value;
    @(posedge clk_i) rst_i |=> st_r.enable == `UIE_ENABLE_RESET;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("enable not 0x06 after reset");

  property p_gate;
    @(posedge clk_i) disable iff (rst_i)
      usb_irq_o == |(st_r.status & st_r.enable & wmask);
  endproperty
  a_gate: assert property (p_gate)
    else $error("request not status and enable");

  property p_top_zero;
    @(posedge clk_i) disable iff (rst_i) st_r.enable[7:6] == 2'b00;
  endproperty
  a_top_zero: assert property (p_top_zero)
    else $error("bits 7:6 not zero");

  property p_write;
    @(posedge clk_i) disable iff (rst_i)
      wr_lane0 && wb_adr_i == `UIE_ADDR_ENABLE
      |=> st_r.enable == ($past(wb_dat_i[7:0]) & 8'h3f);
  endproperty
  a_write: assert property (p_write)
    else $error("enable write not stored");

  property p_dev_read4;
    @(posedge clk_i) disable iff (rst_i)
      req && !host_mode_i && wb_adr_i == `UIE_ADDR_ENABLE
      |=> st_r.dat[4] == 1'b0;
  endproperty
  a_dev_read4: assert property (p_dev_read4)
    else $error("device bit 4 not reserved");

  property p_host_read0;
    @(posedge clk_i) disable iff (rst_i)
      req && host_mode_i && wb_adr_i == `UIE_ADDR_ENABLE
      |=> st_r.dat[0] == 1'b0;
  endproperty
  a_host_read0: assert property (p_host_read0)
    else $error("host bit 0 not reserved");

  property p_babble;
    @(posedge clk_i) disable iff (rst_i)
      host_mode_i && !st_r.sof_seen |-> !qual[`UIE_BIT_BABBLE];
  endproperty
  a_babble: assert property (p_babble)
    else $error("babble before first frame");

  property p_resume;
    @(posedge clk_i) disable iff (rst_i)
      !suspended_i |-> !qual[`UIE_BIT_RESUME];
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume outside suspend");

  sequence s_req;
    req;
  endsequence
  property p_ack;
    @(posedge clk_i) disable iff (rst_i) s_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack not one cycle after request");

  // Bus handshake and read path
  property p_idle_quiet;
    @(posedge clk_i) disable iff (rst_i)
      !req |=> !wb_ack_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("ack without a taken request");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");

  property p_read_top;
    @(posedge clk_i) disable iff (rst_i)
      wb_dat_o[31:8] == 24'h000000;
  endproperty
  a_read_top: assert property (p_read_top)
    else $error("read data upper bits not zero");

  property p_read_role;
    @(posedge clk_i) disable iff (rst_i)
      req && !wb_we_i && wb_adr_i == `UIE_ADDR_ENABLE
      |=> (wb_dat_o[7:0] & ~$past(wmask)) == 8'h00;
  endproperty
  a_read_role: assert property (p_read_role)
    else $error("enable read shows a reserved bit");

  property p_unmapped;
    @(posedge clk_i) disable iff (rst_i)
      req && wb_adr_i != `UIE_ADDR_ENABLE && wb_adr_i != `UIE_ADDR_STATUS
      && wb_adr_i != `UIE_ADDR_MASK |=> wb_dat_o == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  // Bits 7:6 never stored
  property p_status_top;
    @(posedge clk_i) disable iff (rst_i)
      st_r.status[7:6] == 2'b00;
  endproperty
  a_status_top: assert property (p_status_top)
    else $error("status bits 7:6 not zero");

  property p_mask_top;
    @(posedge clk_i) disable iff (rst_i)
      st_r.mask[7:6] == 2'b00;
  endproperty
  a_mask_top: assert property (p_mask_top)
    else $error("mask bits 7:6 not zero");

  // Request gating, independent of the output expression
  property p_no_enable;
    @(posedge clk_i) disable iff (rst_i)
      st_r.enable == 8'h00 |-> !usb_irq_o;
  endproperty
  a_no_enable: assert property (p_no_enable)
    else $error("request with all sources disabled");

  property p_no_status;
    @(posedge clk_i) disable iff (rst_i)
      st_r.status == 8'h00 |-> !usb_irq_o && !irq_o;
  endproperty
  a_no_status: assert property (p_no_status)
    else $error("request with no status bit set");

  property p_irq_unmasked;
    @(posedge clk_i) disable iff (rst_i)
      st_r.mask == 8'h00 |-> !irq_o;
  endproperty
  a_irq_unmasked: assert property (p_irq_unmasked)
    else $error("irq with all sources masked");

  // Reset clears the whole state except enable, which loads 0x06
  property p_reset_clear;
    @(posedge clk_i) rst_i
      |=> st_r.status == 8'h00 && !st_r.sof_seen;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("status or frame flag kept over reset");

  property p_reset_quiet;
    @(posedge clk_i) rst_i
      |=> !wb_ack_o && !usb_irq_o && !irq_o;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active after reset");

  // Enable and mask change only through their own write; status bits clear only through it
  property p_enable_hold;
    @(posedge clk_i) disable iff (rst_i)
      !(wr_lane0 && wb_adr_i == `UIE_ADDR_ENABLE)
      |=> st_r.enable == $past(st_r.enable);
  endproperty
  a_enable_hold: assert property (p_enable_hold)
    else $error("enable changed without a write");

  property p_mask_hold;
    @(posedge clk_i) disable iff (rst_i)
      !(wr_lane0 && wb_adr_i == `UIE_ADDR_MASK)
      |=> st_r.mask == $past(st_r.mask);
  endproperty
  a_mask_hold: assert property (p_mask_hold)
    else $error("mask changed without a write");

  property p_sticky;
    @(posedge clk_i) disable iff (rst_i)
      !(wr_lane0 && wb_adr_i == `UIE_ADDR_STATUS)
      |=> (st_r.status & $past(st_r.status)) == $past(st_r.status);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("status bit lost without a clear");

  property p_set_wins;
    @(posedge clk_i) disable iff (rst_i)
      qual != 8'h00 |=> (st_r.status & $past(qual)) == $past(qual);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost to a clear");

  // Role decides which sources exist
  property p_host_no_suspend;
    @(posedge clk_i) disable iff (rst_i)
      host_mode_i |-> !qual[`UIE_BIT_SUSPEND];
  endproperty
  a_host_no_suspend: assert property (p_host_no_suspend)
    else $error("suspend source live in host role");

  property p_dev_no_connect;
    @(posedge clk_i) disable iff (rst_i)
      !host_mode_i |-> !qual[`UIE_BIT_CONNECT];
  endproperty
  a_dev_no_connect: assert property (p_dev_no_connect)
    else $error("connect source live in device role");

  // Babble arming after the first frame
  property p_sof_arm;
    @(posedge clk_i) disable iff (rst_i)
      host_mode_i && sof_sent_i |=> st_r.sof_seen;
  endproperty
  a_sof_arm: assert property (p_sof_arm)
    else $error("frame sent but babble not armed");

  property p_armed_stays;
    @(posedge clk_i) disable iff (rst_i)
      st_r.sof_seen |=> st_r.sof_seen;
  endproperty
  a_armed_stays: assert property (p_armed_stays)
    else $error("babble arming lost before reset");
endmodule : uie_top

/* File: design/uie_params.svh */
// Constants for the USB interrupt enable block
`ifndef UIE_PARAMS_SVH
`define UIE_PARAMS_SVH
`define UIE_ADDR_ENABLE   8'h0b
`define UIE_ADDR_STATUS   8'h0a
`define UIE_ADDR_MASK     8'h10
`define UIE_ENABLE_RESET  8'h06
`define UIE_HOST_WMASK    8'h3e
`define UIE_DEV_WMASK     8'h2f
`define UIE_BIT_SUSPEND   0
`define UIE_BIT_RESUME    1
`define UIE_BIT_BABBLE    2
`define UIE_BIT_SOF       3
`define UIE_BIT_CONNECT   4
`define UIE_BIT_DISCONNECT_ENABLE    5
`endif

/* File: design/uie_pkg.sv */
// Types for the USB interrupt enable block
package uie_pkg;
  typedef enum logic [1:0] {
    UIE_IDLE = 2'b00,
    UIE_ACK  = 2'b01
  } uie_bus_e;

  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] status;
    logic [7:0] mask;
    logic       sof_seen;
    logic [7:0] dat;
    uie_bus_e   bus;
  } uie_state_s;
endpackage : uie_pkg

/* File: verif/uie_irq_model.sv */
// Interrupt controller model that latches any request it sees
module uie_irq_model (
  input  wire logic clk_i,  // System clock
  input  wire logic rst_i,  // Synchronous reset
  input  wire logic irq_i,  // Request from the block
  output logic      seen_o  // Request latched since reset
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk_i) begin
    if (rst_i) seen_o <= 1'b0;
    else if (irq_i) seen_o <= 1'b1;
  end
endmodule : uie_irq_model

/* File: verif/usb_interrupt_enable_mask_test.sv */
// Register and interrupt tests for the interrupt enable block
module usb_interrupt_enable_mask_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, host_mode_i = 1, suspended_i = 0;
  logic sof_sent_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] event_i = 0, wb_adr_i = 0, q;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 0, wb_dat_o;
  logic wb_ack_o, usb_irq_o, irq_o, seen;
  int failures = 0, n_checks = 0;
  always #50 clk_i = ~clk_i;
  uie_top uut (.clk_i(clk_i), .rst_i(rst_i), .host_mode_i(host_mode_i),
    .suspended_i(suspended_i), .sof_sent_i(sof_sent_i), .event_i(event_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .usb_irq_o(usb_irq_o),
    .irq_o(irq_o));
  uie_irq_model ctl (.clk_i(clk_i), .rst_i(rst_i), .irq_i(usb_irq_o),
    .seen_o(seen));
  task end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    i = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    if (wb_ack_o !== 1'b1) begin
      failures++;
      end_sim();
    end
    q = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : bus
  task rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk("read", e, q);
  endtask : rd
  task ev(input logic [7:0] e, input logic s);
    @(posedge clk_i);
    event_i <= e;
    sof_sent_i <= s;
    @(posedge clk_i);
    event_i <= 8'h00;
    sof_sent_i <= 1'b0;
  endtask : ev
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h0b, 8'h06);
    rd(8'h10, 8'h00);
    bus(1'b1, 8'h0b, 8'hff);
    rd(8'h0b, 8'h3e);
    host_mode_i <= 1'b0;
    rd(8'h0b, 8'h2f);
    rd(8'h20, 8'h00);
    bus(1'b1, 8'h0b, 8'h08);
    ev(8'h08, 1'b0);
    rd(8'h0a, 8'h08);
    chk("usb_irq", 8'h01, {7'h0, usb_irq_o});
    chk("irq", 8'h00, {7'h0, irq_o});
    bus(1'b1, 8'h10, 8'h08);
    // Write lands on the ack edge; outputs settle one edge later
    @(posedge clk_i);
    chk("irq", 8'h01, {7'h0, irq_o});
    bus(1'b1, 8'h0a, 8'h08);
    rd(8'h0a, 8'h00);
    chk("usb_irq", 8'h00, {7'h0, usb_irq_o});
    bus(1'b1, 8'h0b, 8'h00);
    ev(8'h08, 1'b0);
    rd(8'h0a, 8'h08);
    chk("usb_irq", 8'h00, {7'h0, usb_irq_o});
    bus(1'b1, 8'h0a, 8'h08);
    host_mode_i <= 1'b1;
    ev(8'h04, 1'b0);
    rd(8'h0a, 8'h00);
    ev(8'h00, 1'b1);
    ev(8'h04, 1'b0);
    rd(8'h0a, 8'h04);
    bus(1'b1, 8'h0a, 8'h04);
    ev(8'h02, 1'b0);
    rd(8'h0a, 8'h00);
    suspended_i <= 1'b1;
    ev(8'h02, 1'b0);
    rd(8'h0a, 8'h02);
    chk("seen", 8'h01, {7'h0, seen});
    bus(1'b1, 8'h0a, 8'h02);
    // Event in the same cycle as its clear: set wins
    fork
      bus(1'b1, 8'h0a, 8'h08);
      begin
        repeat (2) @(posedge clk_i);
        event_i <= 8'h08;
        @(posedge clk_i);
        event_i <= 8'h00;
      end
    join
    rd(8'h0a, 8'h08);
    bus(1'b1, 8'h0a, 8'h08);
    wb_sel_i <= 4'h0;
    bus(1'b1, 8'h0b, 8'h3e);
    wb_sel_i <= 4'h1;
    bus(1'b1, 8'h20, 8'hff);
    rd(8'h0b, 8'h00);
    bus(1'b1, 8'h0b, 8'h32);
    ev(8'h10, 1'b0);
    rd(8'h0a, 8'h10);
    chk("usb_irq", 8'h01, {7'h0, usb_irq_o});
    bus(1'b1, 8'h0a, 8'h10);
    ev(8'h20, 1'b0);
    rd(8'h0a, 8'h20);
    chk("usb_irq", 8'h01, {7'h0, usb_irq_o});
    bus(1'b1, 8'h0a, 8'h20);
    ev(8'h02, 1'b0);
    rd(8'h0a, 8'h02);
    chk("usb_irq", 8'h01, {7'h0, usb_irq_o});
    bus(1'b1, 8'h0a, 8'h02);
    host_mode_i <= 1'b0;
    bus(1'b1, 8'h0b, 8'h01);
    ev(8'h11, 1'b0);
    rd(8'h0a, 8'h01);
    chk("usb_irq", 8'h01, {7'h0, usb_irq_o});
    host_mode_i <= 1'b1;
    @(posedge clk_i);
    chk("usb_irq", 8'h00, {7'h0, usb_irq_o});
    rd(8'h0b, 8'h00);
    bus(1'b1, 8'h0a, 8'h01);
    // Second reset in mid-run
    bus(1'b1, 8'h0b, 8'h3e);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h0b, 8'h06);
    rd(8'h0a, 8'h00);
    ev(8'h04, 1'b0);
    rd(8'h0a, 8'h00);
    chk("seen", 8'h00, {7'h0, seen});
    end_sim();
  end
endmodule : usb_interrupt_enable_mask_test
